// *** design/async_serial_tx_rx_core.sv ***
// Full-duplex asynchronous serial transmitter and receiver core
// Behaviour
// - Length bit selects 8 or 9 bit characters
// - Frame loads start 0 low, stop 1 high
// - Transfer to shifter sets empty flag, irq
// - Next load at nine sixteenths of stop
// - Enable rise sends 10 or 11 ones first
// - Optional odd/even parity replaces character msb
// - Output idles high when no frame
// - Disable mid-frame finishes frame, then release pin
// - Disable-enable mid-frame queues one idle character
// - Empty flag resets set; write clears it
// - Send-break keeps loading all-zero break characters
// - Break end followed by at least one 1
// - Zero data and zero stop means break
// - Break sets framing error, full, clears data
// - Idle character all ones, length follows mode
// - Complete frame fills buffer, sets full, irq
// - Receiver samples at sixteen times baud
// - Resync after start and one-to-zero bit change
// - Start search: zero after three ones
// - Start verify at phases 3,5,7
// - Zero divisor stops generator; low write commits
// - Pattern with a single 1 (001, 010, 100) verifies noisy; two or more 1s reject, restart
// - Majority of phases 8-10; zero stop frames
// - Break 10/11 or 13/14 bits by select
//
// The register addresses and the strobed register port were left to the implementer.
`include "uart_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module async_serial_tx_rx_core (
  input wire logic clk,
  input wire logic nrst,
  input wire uart_pkg::reg_req_t bus_req,
  output logic [7:0] rd_data,
  input wire logic rxd,
  output logic txd,
  output logic txd_oe_n,
  output logic tx_irq,
  output logic rx_irq
);

  function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
    hit = a == off;
  endfunction : hit

  function automatic logic par(input logic [7:0] d, input logic odd);
    par = (^d) ^ odd;
  endfunction : par

  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : maj3

  // ****************************************
  // Register file
  // ****************************************
  logic [4:0] baud_high_reg;
  logic [12:0] divisor;
  logic [7:0] control_one_reg;
  logic [7:0] control_two_reg;
  logic tx_ninth_bit;
  logic [7:0] data_low_reg;
  logic rx_ninth_bit;
  logic [7:0] rx_buf;
  uart_pkg::status_flags_t flags;
  logic rx_active_flag;

  wire wr_baud_high = bus_req.wr && hit(bus_req.addr, `ADDR_BAUD_HIGH);
  wire wr_baud_low = bus_req.wr && hit(bus_req.addr, `ADDR_BAUD_LOW);
  wire wr_ctrl_one = bus_req.wr && hit(bus_req.addr, `ADDR_CTRL_ONE);
  wire wr_ctrl_two = bus_req.wr && hit(bus_req.addr, `ADDR_CTRL_TWO);
  wire wr_data_high = bus_req.wr && hit(bus_req.addr, `ADDR_DATA_HIGH);
  wire wr_data_low = bus_req.wr && hit(bus_req.addr, `ADDR_DATA_LOW);
  wire rd_data_low = bus_req.rd && hit(bus_req.addr, `ADDR_DATA_LOW);

  wire long_char = control_one_reg[`C1_LONG_CHAR];
  wire long_break_sel = control_one_reg[`C1_LONG_BREAK];
  wire par_en = control_one_reg[`C1_PAR_EN];
  wire par_odd = control_one_reg[`C1_PAR_ODD];
  wire tx_empty_irq_en = control_two_reg[`C2_TX_IRQ_EN];
  wire rx_full_irq_en = control_two_reg[`C2_RX_IRQ_EN];
  wire tx_on = control_two_reg[`C2_TX_ON];
  wire send_break_ctl = control_two_reg[`C2_SEND_BREAK];
  wire tx_on_rise = wr_ctrl_two && bus_req.wdata[`C2_TX_ON] && !tx_on;

  wire [7:0] stat_one = {flags.tx_buffer_empty_flag, flags.tc, flags.rx_full_flag, 2'b00,
                         flags.nf, flags.fe, flags.pf};
  wire [7:0] data_high = {rx_ninth_bit, tx_ninth_bit, 6'h00};
  wire [7:0] rd_mux =
    hit(bus_req.addr, `ADDR_BAUD_HIGH) ? {3'h0, baud_high_reg} :
    hit(bus_req.addr, `ADDR_BAUD_LOW) ? divisor[7:0] :
    hit(bus_req.addr, `ADDR_CTRL_ONE) ? control_one_reg :
    hit(bus_req.addr, `ADDR_CTRL_TWO) ? control_two_reg :
    hit(bus_req.addr, `ADDR_STAT_ONE) ? stat_one :
    hit(bus_req.addr, `ADDR_STAT_TWO) ? {7'h00, rx_active_flag} :
    hit(bus_req.addr, `ADDR_DATA_HIGH) ? data_high :
    rx_buf;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      baud_high_reg <= 5'h00;
      divisor <= `BAUD_RESET;
      control_one_reg <= `CTRL_RESET;
      control_two_reg <= `CTRL_RESET;
      tx_ninth_bit <= 1'b0;
      data_low_reg <= 8'h00;
      rd_data <= 8'h00;
    end else begin
      if (wr_baud_high) begin
        baud_high_reg <= bus_req.wdata[4:0];
      end
      if (wr_baud_low) begin
        divisor <= {baud_high_reg, bus_req.wdata};
      end
      if (wr_ctrl_one) begin
        control_one_reg <= bus_req.wdata;
      end
      if (wr_ctrl_two) begin
        control_two_reg <= bus_req.wdata;
      end
      if (wr_data_high) begin
        tx_ninth_bit <= bus_req.wdata[`DH_TX_NINTH];
      end
      if (wr_data_low) begin
        data_low_reg <= bus_req.wdata;
      end
      rd_data <= bus_req.rd ? rd_mux : 8'h00;
    end
  end

  // ****************************************
  // Baud generator
  // ****************************************
  logic [12:0] baud_cnt;
  logic sample_tick;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      baud_cnt <= 13'h0000;
      sample_tick <= 1'b0;
    end else if (divisor == 13'h0000) begin
      baud_cnt <= 13'h0000;
      sample_tick <= 1'b0;
    end else if (baud_cnt >= divisor - 13'h0001) begin
      baud_cnt <= 13'h0000;
      sample_tick <= 1'b1;
    end else begin
      baud_cnt <= baud_cnt + 13'h0001;
      sample_tick <= 1'b0;
    end
  end

  // ****************************************
  // Transmitter
  // ****************************************
  logic [3:0] tx_phase;
  logic [13:0] tx_sr;
  logic [3:0] tx_left;
  logic tx_active;
  logic pre_pend;
  logic brk_tail;

  wire tx_bound = sample_tick && tx_phase == `LAST_PH;
  wire tx_check = sample_tick && tx_phase == `TX_LOAD_PH &&
                  tx_left == 4'h0 && tx_on;
  wire ld_pre = tx_check && pre_pend;
  wire ld_brk = tx_check && !pre_pend && send_break_ctl;
  wire ld_tail = tx_check && !pre_pend && !send_break_ctl && brk_tail;
  wire ld_data = tx_check && !pre_pend && !send_break_ctl && !brk_tail &&
                 !flags.tx_buffer_empty_flag;
  wire ld_any = ld_pre || ld_brk || ld_tail || ld_data;
  wire tx_done_evt = tx_bound && tx_left == 4'h0;
  wire [3:0] len_char = long_char ? `LEN_LONG : `LEN_SHORT;
  wire [3:0] len_brk = long_break_sel ?
    (long_char ? `BRK_LONG : `BRK_SHORT) : len_char;
  wire bit7_out = par_en ? par({1'b0, data_low_reg[6:0]}, par_odd) :
                  data_low_reg[7];
  wire bit8_out = par_en ? par(data_low_reg, par_odd) : tx_ninth_bit;
  wire [13:0] tx_frame = long_char ?
    {3'h0, 1'b1, bit8_out, data_low_reg, 1'b0} :
    {4'h0, 1'b1, bit7_out, data_low_reg[6:0], 1'b0};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_phase <= 4'h0;
      tx_sr <= 14'h3fff;
      tx_left <= 4'h0;
      tx_active <= 1'b0;
      txd <= 1'b1;
      txd_oe_n <= 1'b1;
      pre_pend <= 1'b0;
      brk_tail <= 1'b0;
    end else begin
      if (sample_tick) begin
        tx_phase <= tx_phase + 4'h1;
      end
      if (tx_bound) begin
        if (tx_left != 4'h0) begin
          txd <= tx_sr[0];
          tx_sr <= {1'b1, tx_sr[13:1]};
          tx_left <= tx_left - 4'h1;
          tx_active <= 1'b1;
        end else begin
          txd <= 1'b1;
          tx_active <= 1'b0;
        end
      end
      if (ld_pre) begin
        tx_sr <= 14'h3fff;
        tx_left <= len_char;
      end
      if (ld_brk) begin
        tx_sr <= 14'h0000;
        tx_left <= len_brk;
      end
      if (ld_tail) begin
        tx_sr <= 14'h3fff;
        tx_left <= 4'h1;
      end
      if (ld_data) begin
        tx_sr <= tx_frame;
        tx_left <= len_char;
      end
      if (ld_pre) begin
        pre_pend <= 1'b0;
      end
      if (tx_on_rise) begin
        pre_pend <= 1'b1;
      end
      if (ld_brk) begin
        brk_tail <= 1'b1;
      end else if (ld_tail) begin
        brk_tail <= 1'b0;
      end
      txd_oe_n <= !(tx_on || tx_active || tx_left != 4'h0);
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  uart_pkg::rx_state_t rx_state;
  logic [2:0] hist;
  logic [3:0] rt;
  logic [3:0] rx_idx;
  logic [1:0] vote;
  logic [8:0] rx_sr;
  logic prev_bit;
  logic last_s;
  logic rx_noise;
  logic [7:0] idle_cnt;

  wire running = rx_state == uart_pkg::rx_run;
  wire hunting = rx_state == uart_pkg::rx_hunt;
  wire [2:0] votes = {vote, rxd};
  wire bit_val = maj3(votes);
  wire bit_noisy = votes != 3'b000 && votes != 3'b111;
  wire [3:0] n_data = long_char ? `DATA_LONG : `DATA_SHORT;
  wire start_seen = sample_tick && hunting &&
                    {hist, rxd} == `START_HIST;
  wire at_verify = sample_tick && running && rx_idx == 4'h0 &&
                   rt == `RT_PH7;
  wire at_decide = sample_tick && running && rx_idx != 4'h0 &&
                   rt == `RT_PH10;
  wire stop_done = at_decide && rx_idx == n_data + 4'h1;
  wire resync = sample_tick && running && rx_idx != 4'h0 && prev_bit &&
                rt < `RT_PH8 && last_s && !rxd;
  wire take_vote = rt == `RT_PH3 || rt == `RT_PH5 || rt == `RT_PH8 ||
                   rt == `RT_PH9;
  wire [8:0] rx_char = long_char ? rx_sr : {1'b0, rx_sr[8:1]};
  wire is_break = !bit_val && rx_char == 9'h000;
  wire par_err = par_en && (long_char ?
    par(rx_char[7:0], par_odd) != rx_char[8] :
    par({1'b0, rx_char[6:0]}, par_odd) != rx_char[7]);
  wire [7:0] idle_last = long_char ? `IDLE_LONG : `IDLE_SHORT;
  wire raf_clear = sample_tick && hunting && rxd && idle_cnt == idle_last;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_state <= uart_pkg::rx_hunt;
      hist <= 3'h0;
      rt <= 4'h0;
      rx_idx <= 4'h0;
      vote <= 2'h0;
      rx_sr <= 9'h000;
      prev_bit <= 1'b0;
      last_s <= 1'b1;
      rx_noise <= 1'b0;
      idle_cnt <= 8'h00;
    end else if (sample_tick) begin
      last_s <= rxd;
      if (hunting && rxd && idle_cnt != idle_last) begin
        idle_cnt <= idle_cnt + 8'h01;
      end else if (!hunting || !rxd) begin
        idle_cnt <= 8'h00;
      end
      case (rx_state)
        uart_pkg::rx_hunt: begin
          hist <= {hist[1:0], rxd};
          if (start_seen) begin
            rx_state <= uart_pkg::rx_run;
            rt <= 4'h1;
            rx_idx <= 4'h0;
            rx_noise <= 1'b0;
            prev_bit <= 1'b0;
          end
        end
        uart_pkg::rx_run: begin
          rt <= rt + 4'h1;
          if (rt == `LAST_PH) begin
            rx_idx <= rx_idx + 4'h1;
          end
          if (take_vote) begin
            vote <= {vote[0], rxd};
          end
          if (at_verify) begin
            if (bit_val) begin
              rx_state <= uart_pkg::rx_hunt;
              hist <= 3'h0;
            end else begin
              rx_noise <= bit_noisy;
            end
          end
          if (at_decide) begin
            rx_noise <= rx_noise || bit_noisy;
            prev_bit <= bit_val;
            if (stop_done) begin
              rx_state <= uart_pkg::rx_hunt;
              hist <= 3'h0;
            end else begin
              rx_sr <= {bit_val, rx_sr[8:1]};
            end
          end
          if (resync) begin
            rt <= 4'h1;
          end
        end
        default: begin
          rx_state <= uart_pkg::rx_hunt;
        end
      endcase
    end
  end

  // ****************************************
  // Flags, receive buffer, requests
  // ****************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      flags <= '{tx_buffer_empty_flag: 1'b1, tc: 1'b1, default: 1'b0};
      rx_active_flag <= 1'b0;
      rx_buf <= 8'h00;
      rx_ninth_bit <= 1'b0;
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
    end else begin
      if (wr_data_low) begin
        flags.tx_buffer_empty_flag <= 1'b0;
      end
      if (ld_data) begin
        flags.tx_buffer_empty_flag <= 1'b1;
      end
      if (tx_done_evt) begin
        flags.tc <= 1'b1;
      end
      if (ld_any) begin
        flags.tc <= 1'b0;
      end
      if (rd_data_low) begin
        flags.rx_full_flag <= 1'b0;
        flags.nf <= 1'b0;
        flags.fe <= 1'b0;
        flags.pf <= 1'b0;
      end
      if (stop_done) begin
        flags.rx_full_flag <= 1'b1;
        flags.fe <= !bit_val;
        flags.nf <= rx_noise || bit_noisy;
        flags.pf <= par_err;
        rx_buf <= is_break ? 8'h00 : rx_char[7:0];
        rx_ninth_bit <= is_break ? 1'b0 : rx_char[8];
      end
      if (raf_clear) begin
        rx_active_flag <= 1'b0;
      end
      if (start_seen) begin
        rx_active_flag <= 1'b1;
      end
      tx_irq <= flags.tx_buffer_empty_flag && tx_empty_irq_en;
      rx_irq <= flags.rx_full_flag && rx_full_irq_en;
    end
  end

endmodule : async_serial_tx_rx_core
`default_nettype wire

// *** design/uart_cfg.svh ***
// Offsets, field positions, reset values and counts of the serial core
`ifndef UART_CFG_SVH
`define UART_CFG_SVH
`define ADDR_BAUD_HIGH 3'h0
`define ADDR_BAUD_LOW 3'h1
`define ADDR_CTRL_ONE 3'h2
`define ADDR_CTRL_TWO 3'h3
`define ADDR_STAT_ONE 3'h4
`define ADDR_STAT_TWO 3'h5
`define ADDR_DATA_HIGH 3'h6
`define ADDR_DATA_LOW 3'h7
`define C1_LONG_CHAR 4
`define C1_LONG_BREAK 2
`define C1_PAR_EN 1
`define C1_PAR_ODD 0
`define C2_TX_IRQ_EN 7
`define C2_RX_IRQ_EN 5
`define C2_TX_ON 3
`define C2_SEND_BREAK 0
`define DH_RX_NINTH 7
`define DH_TX_NINTH 6
`define CTRL_RESET 8'h00
`define BAUD_RESET 13'h0000
`define LEN_SHORT 4'ha
`define LEN_LONG 4'hb
`define BRK_SHORT 4'hd
`define BRK_LONG 4'he
`define DATA_SHORT 4'h8
`define DATA_LONG 4'h9
`define TX_LOAD_PH 4'h8
`define LAST_PH 4'hf
`define RT_PH3 4'h2
`define RT_PH5 4'h4
`define RT_PH7 4'h6
`define RT_PH8 4'h7
`define RT_PH9 4'h8
`define RT_PH10 4'h9
`define START_HIST 4'he
`define IDLE_SHORT 8'h9f
`define IDLE_LONG 8'haf
`endif

// *** design/uart_pkg.sv ***
// Types shared by the serial core
package uart_pkg;
  typedef enum logic [1:0] {
    rx_hunt = 2'b01,
    rx_run = 2'b10
  } rx_state_t;
  typedef struct packed {
    logic tx_buffer_empty_flag;
    logic tc;
    logic rx_full_flag;
    logic nf;
    logic fe;
    logic pf;
  } status_flags_t;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : uart_pkg

// *** dv/async_serial_tx_rx_core_test.sv ***
// Self-checking bench for the serial core
`timescale 1ns/1ps
`default_nettype none
module async_serial_tx_rx_core_test;
  logic clk;
  logic nrst;
  uart_pkg::reg_req_t req;
  logic [7:0] rdata;
  logic rxd;
  logic txd;
  logic oe_n;
  logic tx_irq;
  logic rx_irq;
  int errors;
  int comparisons;
  async_serial_tx_rx_core dut (.clk(clk), .nrst(nrst), .bus_req(req),
    .rd_data(rdata), .rxd(rxd), .txd(txd), .txd_oe_n(oe_n),
    .tx_irq(tx_irq), .rx_irq(rx_irq));
  remote_serial_peer peer (.clk(clk), .txd(txd), .rxd(rxd));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // *****
  // Shared tasks
  // *****
  task summarize;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [2:0] a, input logic [7:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask : wr
  task rd(input logic [2:0] a, output logic [7:0] d);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    #1 d = rdata;
    @(posedge clk);
  endtask : rd
  // *****
  // Scenarios
  // *****
  task t_reset;
    logic [7:0] d;
    rd(3'h4, d);
    chk(d, 16'h00c0);
    rd(3'h5, d);
    chk(d, 16'h0000);
    rd(3'h6, d);
    chk(d, 16'h0000);
  endtask : t_reset
  task t_baud;
    logic [12:0] f;
    logic [7:0] d;
    int t;
    int hi;
    hi = 0;
    wr(3'h3, 8'h08);
    wr(3'h2, 8'h00);
    wr(3'h7, 8'h5a);
    wr(3'h0, 8'h00);
    repeat (300) begin
      @(posedge clk);
      hi += txd;
    end
    chk(hi, 300);
    wr(3'h1, 8'h01);
    peer.grab(f, 10, t);
    chk(t >= 160 && t < 200, 1);
    chk(f, {3'b000, 1'b1, 8'h5a, 1'b0});
    rd(3'h4, d);
    chk(d[7], 1);
  endtask : t_baud
  task t_formats;
    logic [7:0] c1 [4] = '{8'h00, 8'h10, 8'h02, 8'h13};
    logic [12:0] f;
    logic [12:0] e;
    logic [7:0] d;
    int t;
    d = 8'h97;
    wr(3'h3, 8'h88);
    repeat (4) @(posedge clk);
    chk(tx_irq, 1);
    for (int i = 0; i < 4; i++) begin
      case (i)
        0: e = {3'b000, 1'b1, d, 1'b0};
        1: e = {2'b00, 2'b11, d, 1'b0};
        2: e = {3'b000, 1'b1, ^d[6:0], d[6:0], 1'b0};
        default: e = {2'b00, 1'b1, ~^d, d, 1'b0};
      endcase
      wr(3'h2, c1[i]);
      wr(3'h6, 8'h40);
      wr(3'h7, d);
      peer.grab(f, 10 + c1[i][4], t);
      chk(f, e);
    end
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h08);
  endtask : t_formats
  task t_txoff;
    logic [12:0] f;
    int t;
    wr(3'h7, 8'h3c);
    fork
      peer.grab(f, 10, t);
      begin
        wait (txd === 1'b0);
        @(posedge clk);
        wr(3'h3, 8'h00);
      end
    join
    chk(f, {3'b000, 1'b1, 8'h3c, 1'b0});
    repeat (20) @(posedge clk);
    chk(oe_n, 1);
    chk(txd, 1);
    wr(3'h3, 8'h08);
  endtask : t_txoff
  task t_idleq;
    logic [12:0] f;
    int t;
    wr(3'h7, 8'h55);
    wait (txd === 1'b0);
    @(posedge clk);
    wr(3'h3, 8'h00);
    wr(3'h3, 8'h08);
    wr(3'h7, 8'haa);
    repeat (163) @(posedge clk);
    peer.grab(f, 10, t);
    chk(t >= 140 && t < 160, 1);
    chk(f, {3'b000, 1'b1, 8'haa, 1'b0});
  endtask : t_idleq
  task t_break;
    int l;
    int h;
    for (int i = 0; i < 2; i++) begin
      wr(3'h2, i ? 8'h04 : 8'h00);
      wr(3'h3, 8'h09);
      wait (txd === 1'b0);
      @(posedge clk);
      wr(3'h3, 8'h08);
      l = 2;
      while (txd === 1'b0) begin
        @(negedge clk);
        l++;
      end
      chk(l, i ? 208 : 160);
      h = 0;
      repeat (16) begin
        h += txd;
        @(negedge clk);
      end
      chk(h, 16);
    end
    wr(3'h2, 8'h00);
  endtask : t_break
  task t_rx;
    logic [7:0] d;
    wr(3'h3, 8'h28);
    peer.send({3'b000, 1'b1, 8'hc3, 1'b0}, 10, 16);
    repeat (8) @(posedge clk);
    chk(rx_irq, 1);
    rd(3'h4, d);
    chk(d & 8'h27, 8'h20);
    rd(3'h7, d);
    chk(d, 8'hc3);
    repeat (3) @(posedge clk);
    chk(rx_irq, 0);
    wr(3'h2, 8'h10);
    peer.send({2'b00, 2'b11, 8'h3c, 1'b0}, 11, 16);
    rd(3'h6, d);
    chk(d & 8'h80, 8'h80);
    rd(3'h7, d);
    chk(d, 8'h3c);
    wr(3'h2, 8'h00);
    peer.send(13'h0000, 10, 16);
    rd(3'h4, d);
    chk(d & 8'h22, 8'h22);
    rd(3'h7, d);
    chk(d, 8'h00);
    peer.send(13'h0000, 1, 2);
    repeat (200) @(posedge clk);
    rd(3'h4, d);
    chk(d & 8'h20, 8'h00);
  endtask : t_rx
  // *****
  // Sequence and watchdog
  // *****
  initial begin
    errors = 0;
    comparisons = 0;
    nrst = 1'b0;
    req = '0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_baud();
    t_formats();
    t_txoff();
    t_idleq();
    t_break();
    t_rx();
    summarize();
  end
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    summarize();
  end
endmodule : async_serial_tx_rx_core_test
`default_nettype wire

// *** dv/remote_serial_peer.sv ***
// Remote serial device model on the far side of the line
`timescale 1ns/1ps
`default_nettype none
module remote_serial_peer (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  // *****
  // Line driver and line sampler
  // *****
  initial begin
    rxd = 1'b1;
  end
  // Frame bits go out lsb first, w clocks each
  task send(input logic [12:0] bits, input int n, input int w);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (w) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask : send
  // Waits for a start edge, samples each bit mid-way
  task grab(output logic [12:0] f, input int n, output int t);
    f = '0;
    t = 0;
    while (txd !== 1'b0 && t < 5000) begin
      @(negedge clk);
      t++;
    end
    repeat (8) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      repeat (16) @(negedge clk);
    end
  endtask : grab
endmodule : remote_serial_peer
`default_nettype wire

// *** dv/uart_core_sva.sv ***
// Port checker for the serial core
`timescale 1ns/1ps
`default_nettype none
module uart_core_sva (
  input wire logic clk,
  input wire logic nrst,
  input wire uart_pkg::reg_req_t bus_req,
  input wire logic [7:0] rd_data,
  input wire logic rxd,
  input wire logic txd,
  input wire logic txd_oe_n,
  input wire logic tx_irq,
  input wire logic rx_irq
);
  // *****
  // Helper logic and assertions
  // *****
  logic [7:0] run;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Cycles since txd last changed
  always_ff @(posedge clk) begin
    if (!nrst) begin
      run <= 8'hff;
    end else if ($changed(txd)) begin
      run <= 8'h00;
    end else if (run != 8'hff) begin
      run <= run + 8'h01;
    end
  end
  AST_RESET_OUT: assert property (
    $rose(nrst) |-> txd && txd_oe_n && !tx_irq && !rx_irq)
    else $error("outputs not idle after reset");
  AST_RD_ZERO: assert property (
    !$past(bus_req.rd) |-> rd_data == 8'h00)
    else $error("read data outside read answer");
  AST_DH_UNUSED: assert property (
    bus_req.rd && bus_req.addr == 3'h6 |=> rd_data[5:0] == 6'h00)
    else $error("data high unused bits set");
  AST_ST2_UNUSED: assert property (
    bus_req.rd && bus_req.addr == 3'h5 |=> rd_data[7:1] == 7'h00)
    else $error("status two unused bits set");
  AST_IDLE_HIGH: assert property (
    txd_oe_n |-> txd)
    else $error("released line not high");
  AST_DRIVE_FRAME: assert property (
    $fell(txd) |-> !txd_oe_n)
    else $error("low bit while not driving");
  AST_BIT_LEN: assert property (
    $changed(txd) |-> run >= 8'h0f)
    else $error("transmit bit shorter than sixteen ticks");
  AST_RX_IRQ_OFF: assert property (
    bus_req.wr && bus_req.addr == 3'h3 && !bus_req.wdata[5] |-> ##2 !rx_irq)
    else $error("receive irq with enable clear");
  AST_TX_IRQ_OFF: assert property (
    bus_req.wr && bus_req.addr == 3'h3 && !bus_req.wdata[7] |-> ##2 !tx_irq)
    else $error("transmit irq with enable clear");
endmodule : uart_core_sva
bind async_serial_tx_rx_core uart_core_sva chk (.clk(clk), .nrst(nrst),
  .bus_req(bus_req), .rd_data(rd_data), .rxd(rxd), .txd(txd),
  .txd_oe_n(txd_oe_n), .tx_irq(tx_irq), .rx_irq(rx_irq));
`default_nettype wire
